// *** src/sps_pkg.sv ***
// Package of constants and types for the serial peripheral shifter
package sps_pkg;
   // Byte-wide register map over Wishbone (byte addresses, one word each)
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_STAT = 4'h4;
   localparam logic [3:0] ADDR_DATA = 4'h8;
   localparam logic [3:0] ADDR_PWR = 4'hC;
   // Control register fields
   localparam int CTRL_IRQ_EN = 7;
   localparam int CTRL_ENABLE = 6;
   localparam int CTRL_LSB_FIRST = 5;
   localparam int CTRL_MASTER = 4;
   localparam int CTRL_CPOL = 3;
   localparam int CTRL_CPHA = 2;
   // Status register fields
   localparam int STAT_DONE = 7;
   localparam int STAT_WRITE_COLLISION_FLAG = 6;
   localparam int STAT_DOUBLE = 0;
   // Power register field
   localparam int PWR_REDUCE = 0;
   // Reset values
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic PWR_RESET = 1'b1;
   // Bits per byte and FIFO shape
   localparam int BYTE_BITS = 8;
   localparam int FIFO_DEPTH = 16;
   localparam int FIFO_WIDTH = 8;
   // Shift engine states
   typedef enum logic [1:0] {SPS_IDLE, SPS_LEAD, SPS_TRAIL} sps_state_t;
endpackage

// *** src/sps_fifo.sv ***
// Receive FIFO with registered read data
`timescale 1ns/1ps
`default_nettype none
module sps_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_b,
   // Fill side
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [WIDTH-1:0] i_in_data,
   // Drain side
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [WIDTH-1:0] o_out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_ptr;
   logic [AW:0] rd_ptr;
   logic [AW:0] count;
   logic push;
   logic pop;

   // Full and empty derived from the pointer distance
   assign count = wr_ptr - rd_ptr;
   // The output register counts as one of the words, so memory stops one short
   assign o_in_ready = !((count == (AW+1)'(DEPTH)) ||
      (o_out_valid && (count == (AW+1)'(DEPTH - 1))));
   assign push = i_in_valid && o_in_ready;
   assign pop = (!o_out_valid || i_out_ready) && (count != '0);

   // Storage write
   always_ff @(posedge i_clk) begin
      if (push) begin
         mem[wr_ptr[AW-1:0]] <= i_in_data;
      end
   end

   // Pointers
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         if (push) wr_ptr <= wr_ptr + 1'b1;
         if (pop) rd_ptr <= rd_ptr + 1'b1;
      end
   end

   // Output register: one word held until taken
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_out_valid <= 1'b0;
         o_out_data <= '0;
      end else if (pop) begin
         o_out_valid <= 1'b1;
         o_out_data <= mem[rd_ptr[AW-1:0]];
      end else if (i_out_ready) begin
         o_out_valid <= 1'b0;
      end
   end
endmodule // sps_fifo
`default_nettype wire

// *** src/sps_shifter.sv ***
// Serial peripheral shifter: master/slave byte engine with Wishbone registers
`timescale 1ns/1ps
`default_nettype none
module sps_shifter (
   // Clock and reset
   input wire logic I_REF_CLK,
   input wire logic I_RST_B,
   // Wishbone slave
   input wire logic I_WB_CYC,
   input wire logic I_WB_STB,
   input wire logic I_WB_WE,
   input wire logic [3:0] I_WB_ADR,
   input wire logic [3:0] I_WB_SEL,
   input wire logic [31:0] I_WB_DAT,
   output logic [31:0] O_WB_DAT,
   output logic O_WB_ACK,
   // Interrupt request and vector acknowledge
   output logic O_IRQ,
   input wire logic I_IRQ_ACK,
   // SS pin configured as input while master
   input wire logic I_SS_AS_INPUT,
   // SPI pins: output enables are active low
   input wire logic I_SCK,
   output logic O_SCK,
   output logic O_SCK_OE_B,
   input wire logic I_MOSI,
   output logic O_MOSI,
   output logic O_MOSI_OE_B,
   input wire logic I_MISO,
   output logic O_MISO,
   output logic O_MISO_OE_B,
   input wire logic I_SS_B,
   // Receive stream backpressure (drain of receive FIFO)
   output logic O_RX_VALID,
   output logic [7:0] O_RX_DATA,
   input wire logic I_RX_READY
);
   // Pin synchronisers
   logic [1:0] sck_meta;
   logic [1:0] mosi_meta;
   logic [1:0] miso_meta;
   logic [1:0] ss_meta;
   logic sck_s;
   logic sck_d;
   logic ss_s;
   // Registers
   logic [7:0] ctrl;
   logic double_speed;
   logic power_reduce;
   logic done_flag;
   logic write_collision_flag_flag;
   logic stat_seen;
   logic [7:0] rx_buf;
   // Engine
   sps_pkg::sps_state_t state;
   logic [7:0] shreg;
   logic [3:0] bit_cnt;
   logic [6:0] div_cnt;
   logic sample_bit;
   logic busy;
   logic byte_done;
   logic done_raw;
   logic [7:0] rxsh;
   logic [1:0] samp_dly;
   logic [1:0] done_dly;
   logic sample_edge;
   logic setup_edge;
   logic sample_now;
   logic ss_fault;
   // Bus decode
   logic wb_req;
   logic wr_data;
   logic rd_stat;
   logic data_access;
   logic enabled;
   logic is_master;
   logic cpol;
   logic cpha;
   logic lsb_first;
   logic lead_edge;
   logic trail_edge;
   logic tick;
   logic [6:0] half_period;
   logic fifo_ready;
   logic fifo_unused_valid;
   logic [7:0] fifo_unused_data;

   assign enabled = ctrl[sps_pkg::CTRL_ENABLE] && !power_reduce;
   assign is_master = ctrl[sps_pkg::CTRL_MASTER];
   assign cpol = ctrl[sps_pkg::CTRL_CPOL];
   assign cpha = ctrl[sps_pkg::CTRL_CPHA];
   assign lsb_first = ctrl[sps_pkg::CTRL_LSB_FIRST];
   assign wb_req = I_WB_CYC && I_WB_STB && !O_WB_ACK && I_WB_SEL[0];
   assign wr_data = wb_req && I_WB_WE && (I_WB_ADR == sps_pkg::ADDR_DATA);
   assign rd_stat = wb_req && !I_WB_WE && (I_WB_ADR == sps_pkg::ADDR_STAT);
   assign data_access = wb_req && (I_WB_ADR == sps_pkg::ADDR_DATA);
   assign busy = (state != sps_pkg::SPS_IDLE);

   // Two flops on every pin before use
   always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         sck_meta <= 2'h0;
         mosi_meta <= 2'h0;
         miso_meta <= 2'h0;
         ss_meta <= 2'h3;
         sck_d <= 1'b0;
      end else begin
         sck_meta <= {sck_meta[0], I_SCK};
         mosi_meta <= {mosi_meta[0], I_MOSI};
         miso_meta <= {miso_meta[0], I_MISO};
         ss_meta <= {ss_meta[0], I_SS_B};
         sck_d <= sck_meta[1];
      end
   end
   assign sck_s = sck_meta[1];
   assign ss_s = ss_meta[1];

   // Master SS fault: SS as input pulled low while master
   assign ss_fault = enabled && is_master && I_SS_AS_INPUT && !ss_s;

   // Master rate: half period in clocks from rate bits and double speed
   always_comb begin
      case ({double_speed, ctrl[1:0]})
         3'h0: half_period = 7'h02;
         3'h1: half_period = 7'h08;
         3'h2: half_period = 7'h20;
         3'h3: half_period = 7'h40;
         3'h4: half_period = 7'h01;
         3'h5: half_period = 7'h04;
         3'h6: half_period = 7'h10;
         default: half_period = 7'h20;
      endcase
   end

   // Edge detect: generated in master, sampled from SCK in slave
   // Slave edges rely on the far master keeping each SCK level over 2 clocks
   assign tick = (div_cnt == half_period - 7'h01);
   always_comb begin
      if (is_master) begin
         lead_edge = tick && (state == sps_pkg::SPS_LEAD);
         trail_edge = tick && (state == sps_pkg::SPS_TRAIL);
      end else begin
         lead_edge = !ss_s && (sck_s != sck_d) && (sck_s != cpol);
         trail_edge = !ss_s && (sck_s != sck_d) && (sck_s == cpol);
      end
   end
   assign sample_bit = is_master ? miso_meta[1] : mosi_meta[1];
   assign sample_edge = cpha ? trail_edge : lead_edge;
   assign setup_edge = cpha ? lead_edge : trail_edge;

   // Clock divider runs only while a master byte is in flight
   always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         div_cnt <= 7'h00;
      end else if (!is_master || !busy || tick) begin
         div_cnt <= 7'h00;
      end else begin
         div_cnt <= div_cnt + 7'h01;
      end
   end

   // Shift engine
   always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         state <= sps_pkg::SPS_IDLE;
         shreg <= 8'h00;
         bit_cnt <= 4'h0;
         done_raw <= 1'b0;
      end else begin
         done_raw <= 1'b0;
         if (!enabled || ss_fault || (!is_master && ss_s)) begin
            state <= sps_pkg::SPS_IDLE;
            bit_cnt <= 4'h0;
            if (wr_data) shreg <= I_WB_DAT[7:0];
         end else if (wr_data && !busy) begin
            shreg <= I_WB_DAT[7:0];
            bit_cnt <= 4'h0;
            if (is_master) state <= sps_pkg::SPS_LEAD;
         end else begin
            if (!is_master && state == sps_pkg::SPS_IDLE && lead_edge) begin
               state <= sps_pkg::SPS_TRAIL;
            end
            if (is_master && lead_edge) state <= sps_pkg::SPS_TRAIL;
            // Outgoing bits move on the setup edge; with CPHA one the first bit shows unshifted
            if (setup_edge && (!cpha || bit_cnt != 4'h0)) begin
               if (lsb_first) shreg <= {1'b0, shreg[7:1]};
               else shreg <= {shreg[6:0], 1'b0};
            end
            if (sample_edge) bit_cnt <= bit_cnt + 4'h1;
            if (trail_edge && bit_cnt == 4'(sps_pkg::BYTE_BITS - (cpha ? 1 : 0))) begin
               state <= sps_pkg::SPS_IDLE;
               done_raw <= 1'b1;
            end else if (is_master && trail_edge) begin
               state <= sps_pkg::SPS_LEAD;
            end else if (!is_master && trail_edge && bit_cnt == 4'(sps_pkg::BYTE_BITS)) begin
               state <= sps_pkg::SPS_IDLE;
            end
         end
      end
   end

   // Master samples MISO two clocks late so the synchroniser has caught up;
   // done is held back two clocks so the last late bit reaches the buffer
   always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         samp_dly <= 2'h0;
         done_dly <= 2'h0;
      end else begin
         samp_dly <= {samp_dly[0], is_master && sample_edge};
         done_dly <= {done_dly[0], is_master && done_raw};
      end
   end
   assign byte_done = done_dly[1] || (done_raw && !is_master);
   assign sample_now = is_master ? samp_dly[1] : sample_edge;

   // Receive shifter, apart from the transmit one so late samples cannot disturb MOSI
   always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         rxsh <= 8'h00;
      end else if (sample_now) begin
         if (lsb_first) rxsh <= {sample_bit, rxsh[7:1]};
         else rxsh <= {rxsh[6:0], sample_bit};
      end
   end

   // Receive buffer: newest byte overwrites an unread one
   always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         rx_buf <= 8'h00;
      end else if (byte_done) begin
         rx_buf <= rxsh;
      end
   end

   // Control, power and speed registers; master bit drops on SS fault
   always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         ctrl <= sps_pkg::CTRL_RESET;
         power_reduce <= sps_pkg::PWR_RESET;
         double_speed <= 1'b0;
      end else begin
         if (wb_req && I_WB_WE && I_WB_ADR == sps_pkg::ADDR_CTRL) ctrl <= I_WB_DAT[7:0];
         if (wb_req && I_WB_WE && I_WB_ADR == sps_pkg::ADDR_PWR) begin
            power_reduce <= I_WB_DAT[sps_pkg::PWR_REDUCE];
         end
         if (wb_req && I_WB_WE && I_WB_ADR == sps_pkg::ADDR_STAT) begin
            double_speed <= I_WB_DAT[sps_pkg::STAT_DOUBLE];
         end
         if (ss_fault) ctrl[sps_pkg::CTRL_MASTER] <= 1'b0;
      end
   end

   // Done and collision flags; a new event wins over a clear
   always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         done_flag <= 1'b0;
         write_collision_flag_flag <= 1'b0;
         stat_seen <= 1'b0;
      end else begin
         if (rd_stat) begin
            stat_seen <= done_flag || write_collision_flag_flag;
         end else if (data_access) begin
            stat_seen <= 1'b0;
         end
         if (byte_done || ss_fault) begin
            done_flag <= 1'b1;
         end else if (I_IRQ_ACK || (data_access && stat_seen)) begin
            done_flag <= 1'b0;
         end
         if (wr_data && busy) begin
            write_collision_flag_flag <= 1'b1;
         end else if (data_access && stat_seen) begin
            write_collision_flag_flag <= 1'b0;
         end
      end
   end

   // Bus answer one cycle after the request; unmapped reads give zero
   always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         O_WB_ACK <= 1'b0;
         O_WB_DAT <= 32'h00000000;
      end else begin
         O_WB_ACK <= I_WB_CYC && I_WB_STB && !O_WB_ACK;
         case (I_WB_ADR)
            sps_pkg::ADDR_CTRL: O_WB_DAT <= {24'h000000, ctrl};
            sps_pkg::ADDR_STAT: O_WB_DAT <= {24'h000000, done_flag, write_collision_flag_flag, 5'h00, double_speed};
            sps_pkg::ADDR_DATA: O_WB_DAT <= {24'h000000, rx_buf};
            sps_pkg::ADDR_PWR: O_WB_DAT <= {31'h00000000, power_reduce};
            default: O_WB_DAT <= 32'h00000000;
         endcase
      end
   end

   // Interrupt output
   always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         O_IRQ <= 1'b0;
      end else begin
         O_IRQ <= done_flag && ctrl[sps_pkg::CTRL_IRQ_EN] && enabled;
      end
   end

   // Pin drive: outputs come from flops; SS is never driven here
   always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         O_SCK <= 1'b0;
         O_SCK_OE_B <= 1'b1;
         O_MOSI <= 1'b0;
         O_MOSI_OE_B <= 1'b1;
         O_MISO <= 1'b0;
         O_MISO_OE_B <= 1'b1;
      end else begin
         O_SCK <= (state == sps_pkg::SPS_TRAIL) ? !cpol : cpol;
         O_SCK_OE_B <= !(enabled && is_master);
         O_MOSI <= lsb_first ? shreg[0] : shreg[7];
         O_MOSI_OE_B <= !(enabled && is_master);
         O_MISO <= lsb_first ? shreg[0] : shreg[7];
         O_MISO_OE_B <= !(enabled && !is_master && !ss_s);
      end
   end

   // Each completed byte is also streamed through a FIFO, which drops it when full
   sps_fifo #(
      .WIDTH(sps_pkg::FIFO_WIDTH),
      .DEPTH(sps_pkg::FIFO_DEPTH)
   ) u_rx_fifo (
      .i_clk(I_REF_CLK),
      .i_rst_b(I_RST_B),
      .i_in_valid(byte_done),
      .o_in_ready(fifo_ready),
      .i_in_data(rxsh),
      .o_out_valid(fifo_unused_valid),
      .i_out_ready(I_RX_READY),
      .o_out_data(fifo_unused_data)
   );

   // Stream outputs mirror the FIFO output register
   assign O_RX_VALID = fifo_unused_valid;
   assign O_RX_DATA = fifo_unused_data;
endmodule // sps_shifter
`default_nettype wire

// *** tb/sps_shifter_chk.sv ***
// Port-level assertions for the serial peripheral shifter
`timescale 1ns/1ps
`default_nettype none
module sps_shifter_chk (
   // Clock and reset
   input wire logic I_REF_CLK,
   input wire logic I_RST_B,
   // Register bus
   input wire logic I_WB_CYC,
   input wire logic I_WB_STB,
   input wire logic [31:0] O_WB_DAT,
   input wire logic O_WB_ACK,
   // Link pins
   input wire logic I_SS_B,
   input wire logic O_SCK_OE_B,
   input wire logic O_MOSI_OE_B,
   input wire logic O_MISO_OE_B,
   // Receive stream
   input wire logic O_RX_VALID,
   input wire logic [7:0] O_RX_DATA,
   input wire logic I_RX_READY
);
   default clocking cb @(posedge I_REF_CLK); endclocking
   default disable iff (!I_RST_B);
   // A bus request still waiting, and a stalled stream word
   sequence s_req; I_WB_CYC && I_WB_STB && !O_WB_ACK; endsequence
   sequence s_stall; O_RX_VALID && !I_RX_READY; endsequence
   property p_ack_next; s_req |=> O_WB_ACK; endproperty
   property p_ack_drop; s_req ##1 O_WB_ACK |=> !O_WB_ACK; endproperty
   property p_ack_cause; $rose(O_WB_ACK) |-> $past(I_WB_STB); endproperty
   property p_dat_upper; O_WB_ACK |-> O_WB_DAT[31:8] == 24'h0; endproperty
   property p_miso_release; I_SS_B [*4] |-> O_MISO_OE_B; endproperty
   property p_no_fight; !O_MISO_OE_B |-> O_MOSI_OE_B && O_SCK_OE_B; endproperty
   property p_master_pair; O_MOSI_OE_B == O_SCK_OE_B; endproperty
   property p_rx_hold; s_stall |=> O_RX_VALID && $stable(O_RX_DATA); endproperty
   a_ack_next: assert property (p_ack_next) else $error("bus answer late");
   a_ack_drop: assert property (p_ack_drop) else $error("bus answer held too long");
   a_ack_cause: assert property (p_ack_cause) else $error("bus answer without request");
   a_dat_upper: assert property (p_dat_upper) else $error("upper read bits not zero");
   a_miso_release: assert property (p_miso_release) else $error("data out held while idle");
   a_no_fight: assert property (p_no_fight) else $error("both link directions driven");
   a_master_pair: assert property (p_master_pair) else $error("clock and data out split");
   a_rx_hold: assert property (p_rx_hold) else $error("stream word changed in stall");
endmodule // sps_shifter_chk
`default_nettype wire

// *** tb/sps_partner.sv ***
// Behavioural far-side slave: mode 0, most significant bit first
`timescale 1ns/1ps
`default_nettype none
module sps_partner (
   // Link pins
   input wire logic i_sck,
   input wire logic i_mosi,
   input wire logic i_ss_b,
   output logic o_miso = 1'b0,
   // Byte to answer with and byte taken in
   input wire logic [7:0] i_reply,
   output logic [7:0] o_rx = 8'h00
);
   logic [7:0] sh = 8'h00;
   // Selection loads the answer and puts its first bit out
   always @(negedge i_ss_b) begin
      sh = i_reply;
      o_miso = sh[7];
   end
   // Sample on the rising clock edge, set up the next bit on the falling one
   always @(posedge i_sck) if (!i_ss_b) o_rx = {o_rx[6:0], i_mosi};
   always @(negedge i_sck) if (!i_ss_b) begin
      sh = {sh[6:0], 1'b0};
      o_miso = sh[7];
   end
   // No pull on the line: a released line must not keep looking valid
   always @(posedge i_ss_b) o_miso = ~o_miso;
endmodule // sps_partner
`default_nettype wire

// *** tb/sps_shifter_tb.sv ***
// Self-checking bench for the serial peripheral shifter
`timescale 1ns/1ps
`default_nettype none
module sps_shifter_tb;
   localparam logic [3:0] A_CTL = sps_pkg::ADDR_CTRL;
   localparam logic [3:0] A_ST = sps_pkg::ADDR_STAT;
   localparam logic [3:0] A_DAT = sps_pkg::ADDR_DATA;
   logic clk = 0, rst_b = 0, cyc = 0, we = 0, irq_ack = 0, ss_in = 0, sck = 0, mosi = 0;
   logic ss_b = 1, rdy = 0, hold = 0, o_ack, o_irq, o_sck, o_sck_oe_b, o_mosi, o_mosi_oe_b;
   logic o_miso, o_miso_oe_b, o_rx_valid, p_miso;
   logic [3:0] adr = 4'h0;
   logic [31:0] wdat = 32'h0, o_wb_dat, exp_q[$];
   logic [7:0] o_rx_data, p_rx, reply = 8'h00, tx, rep, got, rx_q[$];
   int n_fail = 0, check_count = 0;
   // Each pin level is whoever drives it at the moment
   wire logic sck_w = o_sck_oe_b ? sck : o_sck;
   wire logic mosi_w = o_mosi_oe_b ? mosi : o_mosi;
   wire logic miso_w = o_miso_oe_b ? p_miso : o_miso;
   sps_shifter dut (.I_REF_CLK(clk), .I_RST_B(rst_b), .I_WB_CYC(cyc), .I_WB_STB(cyc),
      .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(4'hF), .I_WB_DAT(wdat), .O_WB_DAT(o_wb_dat),
      .O_WB_ACK(o_ack), .O_IRQ(o_irq), .I_IRQ_ACK(irq_ack), .I_SS_AS_INPUT(ss_in),
      .I_SCK(sck_w), .O_SCK(o_sck), .O_SCK_OE_B(o_sck_oe_b), .I_MOSI(mosi_w),
      .O_MOSI(o_mosi), .O_MOSI_OE_B(o_mosi_oe_b), .I_MISO(miso_w), .O_MISO(o_miso),
      .O_MISO_OE_B(o_miso_oe_b), .I_SS_B(ss_b), .O_RX_VALID(o_rx_valid),
      .O_RX_DATA(o_rx_data), .I_RX_READY(rdy));
   sps_partner part (.i_sck(sck_w), .i_mosi(mosi_w), .i_ss_b(ss_b), .o_miso(p_miso),
      .i_reply(reply), .o_rx(p_rx));
   always #2 clk = ~clk;
   // Stream consumer stalls at random unless a fill test holds it off
   always @(posedge clk) rdy <= hold ? 1'b0 : 1'($urandom);
   task automatic check(input string name, input logic [31:0] seen, exp);
      check_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // Results are matched against the oldest note as they appear
   always @(posedge clk) begin
      if (o_ack && !we && exp_q.size() > 0) check("bus_read", o_wb_dat, exp_q.pop_front());
      if (o_rx_valid && rdy) check("rx_word", {24'h0, o_rx_data},
         rx_q.size() > 0 ? {24'h0, rx_q.pop_front()} : 32'hFFFFFFFF);
   end
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      @(posedge clk);
      for (int t = 0; t < 64 && !o_ack; t++) @(posedge clk);
      if (!o_ack) n_fail++;
      cyc <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      wb(1'b0, a, 32'h0);
   endtask
   task automatic ack;
      irq_ack <= 1'b1;
      @(posedge clk);
      irq_ack <= 1'b0;
      @(posedge clk);
   endtask
   // Master byte: software selects the far slave, the data write starts the clock
   task automatic mx(input logic [7:0] t, r);
      reply <= r;
      ss_b <= 1'b0;
      @(posedge clk);
      wb(1'b1, A_DAT, {24'h0, t});
      for (int i = 0; i < 400 && !o_irq; i++) @(posedge clk);
      ss_b <= 1'b1;
      check("far_rx", {24'h0, p_rx}, {24'h0, t});
   endtask
   // Bench as far master: 80 ns link clock, runs only inside the frame
   task automatic sx(input logic [7:0] t, input int nb);
      ss_b <= 1'b0;
      repeat (10) @(posedge clk);
      for (int b = 7; b >= 8 - nb; b--) begin
         mosi <= t[b];
         repeat (10) @(posedge clk);
         sck <= 1'b1;
         got = {got[6:0], miso_w};
         repeat (10) @(posedge clk);
         sck <= 1'b0;
      end
      repeat (10) @(posedge clk);
      ss_b <= 1'b1;
      mosi <= ~mosi;
      repeat (4) @(posedge clk);
   endtask
   task automatic results;
      $display("Comparisons %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial begin
      #200000;
      n_fail++;
      results();
   end
   initial begin
      void'($urandom(32'hD0F516C1));
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      // Reset values, an unmapped place, then a start that the power gate must block
      rd(sps_pkg::ADDR_PWR, 32'h1);
      rd(A_CTL, 32'h0);
      rd(4'h1, 32'h0);
      wb(1'b1, A_CTL, 32'hD0);
      wb(1'b1, A_DAT, 32'hA5);
      repeat (60) @(posedge clk);
      rd(A_ST, 32'h0);
      wb(1'b1, sps_pkg::ADDR_PWR, 32'h0);
      $display("power gate done");
      // Master bytes at two rates, flag then status-read plus data-read clearing
      for (int i = 0; i < 4; i++) begin
         wb(1'b1, A_CTL, 32'hD0 | 32'(i / 2));
         tx = 8'($urandom);
         rep = 8'($urandom);
         rx_q.push_back(rep);
         mx(tx, rep);
         rd(A_ST, 32'h80);
         rd(A_DAT, {24'h0, rep});
         rd(A_ST, 32'h0);
         check("irq_low", {31'h0, o_irq}, 32'h0);
      end
      $display("master bytes done");
      // Second write mid-byte is refused and flagged; interrupt masked
      wb(1'b1, A_CTL, 32'h50);
      rx_q.push_back(rep);
      reply <= rep;
      ss_b <= 1'b0;
      wb(1'b1, A_DAT, {24'h0, tx});
      wb(1'b1, A_DAT, {24'h0, ~tx});
      repeat (48) @(posedge clk);
      ss_b <= 1'b1;
      check("masked_irq", {31'h0, o_irq}, 32'h0);
      check("far_rx", {24'h0, p_rx}, {24'h0, tx});
      rd(A_ST, 32'hC0);
      ack();
      rd(A_ST, 32'h40);
      rd(A_DAT, {24'h0, rep});
      rd(A_ST, 32'h0);
      $display("collision done");
      // Stalled stream: sixteen bytes kept, the seventeenth dropped
      repeat (40) @(posedge clk);
      hold <= 1'b1;
      wb(1'b1, A_CTL, 32'hD0);
      for (int i = 0; i < 17; i++) begin
         rep = 8'($urandom);
         if (i < 16) rx_q.push_back(rep);
         mx(8'($urandom), rep);
         ack();
      end
      rd(A_DAT, {24'h0, rep});
      hold <= 1'b0;
      repeat (200) @(posedge clk);
      check("rx_left", 32'(rx_q.size()), 32'h0);
      $display("fill done");
      // Slave: load while deselected, full byte, early reload, partial frame dropped
      wb(1'b1, A_CTL, 32'h40);
      tx = 8'($urandom);
      rep = 8'($urandom);
      wb(1'b1, A_DAT, {24'h0, tx});
      rx_q.push_back(rep);
      sx(rep, 8);
      check("slave_out", {24'h0, got}, {24'h0, tx});
      rd(A_ST, 32'h80);
      wb(1'b1, A_DAT, 32'h3C);
      rd(A_DAT, {24'h0, rep});
      sx(8'hFF, 3);
      rd(A_ST, 32'h0);
      rep = 8'($urandom);
      rx_q.push_back(rep);
      sx(rep, 8);
      rd(A_DAT, {24'h0, rep});
      $display("slave done");
      // Master with SS as input pulled low turns slave
      wb(1'b1, A_CTL, 32'h50);
      ss_in <= 1'b1;
      ss_b <= 1'b0;
      repeat (8) @(posedge clk);
      rd(A_CTL, 32'h40);
      rd(A_ST, 32'h80);
      ss_b <= 1'b1;
      repeat (100) @(posedge clk);
      $display("mode fault done");
      results();
   end
endmodule // sps_shifter_tb
bind sps_shifter sps_shifter_chk chk (.I_REF_CLK(I_REF_CLK), .I_RST_B(I_RST_B),
   .I_WB_CYC(I_WB_CYC), .I_WB_STB(I_WB_STB), .O_WB_DAT(O_WB_DAT), .O_WB_ACK(O_WB_ACK),
   .I_SS_B(I_SS_B), .O_SCK_OE_B(O_SCK_OE_B), .O_MOSI_OE_B(O_MOSI_OE_B),
   .O_MISO_OE_B(O_MISO_OE_B), .O_RX_VALID(O_RX_VALID), .O_RX_DATA(O_RX_DATA),
   .I_RX_READY(I_RX_READY));
`default_nettype wire
